// *** hw/llmdec_defines.vh ***
// Opcode, selector and issue-count constants for the load/loop/move decoder
`ifndef LLMDEC_DEFINES_VH
`define LLMDEC_DEFINES_VH

`define LLMDEC_OP_ESC       8'h0F
`define LLMDEC_OP_LEA       8'h8D
`define LLMDEC_OP_LDPES     8'hC4
`define LLMDEC_OP_LEAVE     8'hC9
`define LLMDEC_OP_LOOP      8'hE2
`define LLMDEC_OP_LOOPNZ    8'hE0
`define LLMDEC_OP_LOOPZ     8'hE1
`define LLMDEC_OP_MOVI_HI   4'hB
`define LLMDEC_OP_MOVA_HI   4'hA
`define LLMDEC_OP_MOVA_LO   3'h0
`define LLMDEC_OP2_LDPFS    8'hB4
`define LLMDEC_OP2_LDPGS    8'hB5
`define LLMDEC_OP2_LDPSS    8'hB2
`define LLMDEC_OP2_GRP6     8'h00
`define LLMDEC_OP2_GRP7     8'h01
`define LLMDEC_OP2_SEGLIM   8'h03
`define LLMDEC_REG_LDTAB    3'h2
`define LLMDEC_REG_TASK     3'h3
`define LLMDEC_REG_GDT      3'h2
`define LLMDEC_REG_IDT      3'h3
`define LLMDEC_REG_MSW      3'h6

// Issue clock counts on a cache hit, real/protected
`define LLMDEC_CLK_LEA      4'h1
`define LLMDEC_CLK_LDP_R    4'h4
`define LLMDEC_CLK_LDP_P    4'h9
`define LLMDEC_CLK_LDPSS_P  4'hA
`define LLMDEC_CLK_DTAB     4'hA
`define LLMDEC_CLK_LDTAB    4'h8
`define LLMDEC_CLK_TASK     4'h9
`define LLMDEC_CLK_MSW      4'hB
`define LLMDEC_CLK_SEGLIM   4'h9
`define LLMDEC_CLK_LEAVE    4'h4
`define LLMDEC_CLK_LOOP     4'h2
`define LLMDEC_CLK_MOV      4'h1

// Operation codes handed to the pipeline
`define LLMDEC_K_NONE       5'h00
`define LLMDEC_K_LEA        5'h01
`define LLMDEC_K_LDPES      5'h02
`define LLMDEC_K_LDPFS      5'h03
`define LLMDEC_K_LDPGS      5'h04
`define LLMDEC_K_LDPSS      5'h05
`define LLMDEC_K_GDT        5'h06
`define LLMDEC_K_IDT        5'h07
`define LLMDEC_K_LDTAB      5'h08
`define LLMDEC_K_TASK       5'h09
`define LLMDEC_K_MSW        5'h0A
`define LLMDEC_K_SEGLIM     5'h0B
`define LLMDEC_K_LEAVE      5'h0C
`define LLMDEC_K_LOOP       5'h0D
`define LLMDEC_K_LOOPNZ     5'h0E
`define LLMDEC_K_LOOPZ      5'h0F
`define LLMDEC_K_MOVI       5'h10
`define LLMDEC_K_MOVA       5'h11

`endif

// *** hw/llmdec_table.v ***
// Combinational opcode table: operation, clock count, ModR/M need, flag effect
`timescale 1ns/100ps
`default_nettype none
`include "llmdec_defines.vh"

module llmdec_table (
    // Instruction bytes
    input  wire       esc_in,
    input  wire [7:0] op_in,
    input  wire [2:0] reg_in,
    input  wire       prot_in,
    // Decode result
    output reg  [4:0] kind_out,
    output reg  [3:0] clocks_out,
    output reg        modrm_out,
    output reg        zf_only_out,
    output reg        legal_out
);

    always @* begin
        kind_out    = `LLMDEC_K_NONE;
        clocks_out  = 4'h0;
        modrm_out   = 1'b0;
        zf_only_out = 1'b0;
        legal_out   = 1'b0;
        if (!esc_in) begin
            if (op_in == `LLMDEC_OP_LEA) begin
                kind_out = `LLMDEC_K_LEA;
                clocks_out = `LLMDEC_CLK_LEA;                      // [RQ1]
                modrm_out = 1'b1;
                legal_out = 1'b1;
            end else if (op_in == `LLMDEC_OP_LDPES) begin
                kind_out = `LLMDEC_K_LDPES;
                clocks_out = prot_in ? `LLMDEC_CLK_LDP_P : `LLMDEC_CLK_LDP_R; // [RQ2]
                modrm_out = 1'b1;
                legal_out = 1'b1;
            end else if (op_in == `LLMDEC_OP_LEAVE) begin
                kind_out = `LLMDEC_K_LEAVE;
                clocks_out = `LLMDEC_CLK_LEAVE;                    // [RQ12]
                legal_out = 1'b1;
            end else if (op_in == `LLMDEC_OP_LOOP || op_in == `LLMDEC_OP_LOOPNZ
                         || op_in == `LLMDEC_OP_LOOPZ) begin
                kind_out = (op_in == `LLMDEC_OP_LOOP) ? `LLMDEC_K_LOOP :
                           (op_in == `LLMDEC_OP_LOOPNZ) ? `LLMDEC_K_LOOPNZ :
                           `LLMDEC_K_LOOPZ;
                clocks_out = `LLMDEC_CLK_LOOP;                     // [RQ13]
                legal_out = 1'b1;
            end else if (op_in[7:4] == `LLMDEC_OP_MOVI_HI) begin
                kind_out = `LLMDEC_K_MOVI;
                clocks_out = `LLMDEC_CLK_MOV;                      // [RQ14]
                legal_out = 1'b1;
            end else if (op_in[7:4] == `LLMDEC_OP_MOVA_HI
                         && op_in[3:1] == `LLMDEC_OP_MOVA_LO) begin
                kind_out = `LLMDEC_K_MOVA;
                clocks_out = `LLMDEC_CLK_MOV;                      // [RQ15]
                legal_out = 1'b1;
            end
        end else begin
            modrm_out = 1'b1;
            case (op_in)
                `LLMDEC_OP2_LDPFS: begin
                    kind_out = `LLMDEC_K_LDPFS;
                    clocks_out = prot_in ? `LLMDEC_CLK_LDP_P : `LLMDEC_CLK_LDP_R; // [RQ3]
                    legal_out = 1'b1;
                end
                `LLMDEC_OP2_LDPGS: begin
                    kind_out = `LLMDEC_K_LDPGS;
                    clocks_out = prot_in ? `LLMDEC_CLK_LDP_P : `LLMDEC_CLK_LDP_R; // [RQ4]
                    legal_out = 1'b1;
                end
                `LLMDEC_OP2_LDPSS: begin
                    kind_out = `LLMDEC_K_LDPSS;
                    clocks_out = prot_in ? `LLMDEC_CLK_LDPSS_P : `LLMDEC_CLK_LDP_R; // [RQ5]
                    legal_out = 1'b1;
                end
                `LLMDEC_OP2_GRP7: begin
                    if (reg_in == `LLMDEC_REG_GDT) begin
                        kind_out = `LLMDEC_K_GDT;
                        clocks_out = `LLMDEC_CLK_DTAB;             // [RQ6]
                        legal_out = 1'b1;
                    end else if (reg_in == `LLMDEC_REG_IDT) begin
                        kind_out = `LLMDEC_K_IDT;
                        clocks_out = `LLMDEC_CLK_DTAB;             // [RQ7]
                        legal_out = 1'b1;
                    end else if (reg_in == `LLMDEC_REG_MSW) begin
                        kind_out = `LLMDEC_K_MSW;
                        clocks_out = `LLMDEC_CLK_MSW;              // [RQ10]
                        legal_out = 1'b1;
                    end
                end
                `LLMDEC_OP2_GRP6: begin
                    // Only timed for protected mode; refused in real mode
                    if (prot_in && reg_in == `LLMDEC_REG_LDTAB) begin
                        kind_out = `LLMDEC_K_LDTAB;
                        clocks_out = `LLMDEC_CLK_LDTAB;            // [RQ8]
                        legal_out = 1'b1;
                    end else if (prot_in && reg_in == `LLMDEC_REG_TASK) begin
                        kind_out = `LLMDEC_K_TASK;
                        clocks_out = `LLMDEC_CLK_TASK;             // [RQ9]
                        legal_out = 1'b1;
                    end
                end
                `LLMDEC_OP2_SEGLIM: begin
                    if (prot_in) begin
                        kind_out = `LLMDEC_K_SEGLIM;
                        clocks_out = `LLMDEC_CLK_SEGLIM;           // [RQ11]
                        zf_only_out = 1'b1;                        // [RQ11]
                        legal_out = 1'b1;
                    end
                end
                default: begin
                    legal_out = 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** hw/llmdec_core.v ***
// Byte-serial decoder and issue timer for load, loop and short move opcodes
//
// What this block does
// [RQ1] 8D with ModR/M is address load, 1 clock, flags kept.
// [RQ2] C4 with ModR/M loads far pointer into extra segment; 4 real, 9 prot.
// [RQ3] 0F B4 loads far pointer into F segment; 4 real, 9 prot.
// [RQ4] 0F B5 loads far pointer into G segment; 4 real, 9 prot.
// [RQ5] 0F B2 loads far pointer into stack segment; 4 real, 10 prot.
// [RQ6] 0F 01 reg 010 loads global descriptor table register; 10 clocks.
// [RQ7] 0F 01 reg 011 loads interrupt descriptor table register; 10 clocks.
// [RQ8] 0F 00 reg 010 loads local descriptor table register; 8 clocks prot.
// [RQ9] 0F 00 reg 011 loads task register; 9 clocks prot.
// [RQ10] 0F 01 reg 110 loads machine status word; 11 clocks.
// [RQ11] 0F 03 with ModR/M is segment limit load; 9 prot, alters zero flag.
// [RQ12] C9 leaves stack frame; 4 clocks, flags kept.
// [RQ13] E2, E0, E1 loops take 8-bit offset; 2 clocks, flags kept.
// [RQ14] Bx moves immediate into register; width bit and register in low bits; 1 clock.
// [RQ15] A0/A1 moves memory into accumulator after address bytes; 1 clock.
// [RQ16] Counts assume cache hits; a miss stall holds issue beyond them.
`timescale 1ns/100ps
`default_nettype none
`include "llmdec_defines.vh"

module llmdec_core #(
    parameter ADDR_BYTES = 4
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        nrst_in,
    // Mode
    input  wire        prot_mode_in,
    input  wire        opsize32_in,
    // Byte stream from fetch
    input  wire        byte_valid_in,
    input  wire [7:0]  byte_in,
    output reg         byte_ready_out,
    // Cache miss stall
    input  wire        miss_stall_in,
    // Issue to pipeline
    output reg         issue_out,
    output reg  [4:0]  kind_out,
    output reg  [3:0]  clocks_out,
    output reg  [7:0]  modrm_out,
    output reg  [2:0]  reg_num_out,
    output reg         wide_out,
    output reg         zf_only_out,
    output reg  [31:0] imm_out,
    output reg         busy_out,
    output reg         illegal_out
);

    localparam ST_OP    = 3'h0;
    localparam ST_OP2   = 3'h1;
    localparam ST_MODRM = 3'h2;
    localparam ST_IMM   = 3'h3;
    localparam ST_EXEC  = 3'h4;

    reg  [2:0]  state;
    reg         esc;
    reg  [7:0]  op;
    reg  [2:0]  imm_left;
    reg  [1:0]  imm_pos;
    reg  [3:0]  exec_left;

    wire        take = byte_valid_in && byte_ready_out;
    wire        st_op = (state == ST_OP);
    // Table sees the live byte while the opcode arrives, the held one afterwards
    wire        t_esc = st_op ? 1'b0 : esc;
    wire [7:0]  t_op = (st_op || state == ST_OP2) ? byte_in : op;
    wire [4:0]  t_kind;
    wire [3:0]  t_clocks;
    wire        t_modrm;
    wire        t_zf;
    wire        t_legal;

    // Group opcodes need the reg field before they resolve
    llmdec_table u_table (
        .esc_in      (t_esc),
        .op_in       (t_op),
        .reg_in      (byte_in[5:3]),
        .prot_in     (prot_mode_in),
        .kind_out    (t_kind),
        .clocks_out  (t_clocks),
        .modrm_out   (t_modrm),
        .zf_only_out (t_zf),
        .legal_out   (t_legal)
    );

    // imm_out holds four bytes, so ADDR_BYTES must stay at 4 or below
    wire [2:0]  imm_len = opsize32_in ? 3'h4 : 3'h2;
    wire [2:0]  addr_len = ADDR_BYTES[2:0];

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_OP;
            esc <= 1'b0;
            op <= 8'h00;
            imm_left <= 3'h0;
            imm_pos <= 2'h0;
            exec_left <= 4'h0;
            byte_ready_out <= 1'b0;
            issue_out <= 1'b0;
            kind_out <= 5'h00;
            clocks_out <= 4'h0;
            modrm_out <= 8'h00;
            reg_num_out <= 3'h0;
            wide_out <= 1'b0;
            zf_only_out <= 1'b0;
            imm_out <= 32'h00000000;
            busy_out <= 1'b0;
            illegal_out <= 1'b0;
        end else begin
            issue_out <= 1'b0;
            illegal_out <= 1'b0;
            case (state)
                ST_OP: begin
                    byte_ready_out <= 1'b1;
                    if (take) begin
                        op <= byte_in;
                        esc <= 1'b0;
                        // Fields of the last instruction stand until a new opcode arrives
                        imm_out <= 32'h00000000;
                        imm_pos <= 2'h0;
                        zf_only_out <= 1'b0;
                        modrm_out <= 8'h00;
                        if (byte_in == `LLMDEC_OP_ESC) begin
                            esc <= 1'b1;
                            state <= ST_OP2;
                        end else if (!t_legal) begin
                            illegal_out <= 1'b1;
                        end else begin
                            kind_out <= t_kind;
                            clocks_out <= t_clocks;
                            wide_out <= byte_in[0];
                            reg_num_out <= 3'h0;
                            if (t_kind == `LLMDEC_K_MOVI) begin
                                wide_out <= byte_in[3];                  // [RQ14]
                                reg_num_out <= byte_in[2:0];             // [RQ14]
                                imm_left <= byte_in[3] ? imm_len : 3'h1; // [RQ14]
                                state <= ST_IMM;
                            end else if (t_kind == `LLMDEC_K_MOVA) begin
                                imm_left <= addr_len;                    // [RQ15]
                                state <= ST_IMM;
                            end else if (t_kind == `LLMDEC_K_LOOP
                                         || t_kind == `LLMDEC_K_LOOPNZ
                                         || t_kind == `LLMDEC_K_LOOPZ) begin
                                imm_left <= 3'h1;                        // [RQ13]
                                state <= ST_IMM;
                            end else if (t_modrm) begin
                                state <= ST_MODRM;                       // [RQ1] [RQ2]
                            end else begin
                                state <= ST_EXEC;                        // [RQ12]
                                byte_ready_out <= 1'b0;
                                busy_out <= 1'b1;
                                exec_left <= t_clocks;
                            end
                        end
                    end
                end
                ST_OP2: begin
                    if (take) begin
                        op <= byte_in;
                        // Two-byte opcodes carry their width bit in the second byte
                        wide_out <= byte_in[0];
                        state <= ST_MODRM;
                    end
                end
                ST_MODRM: begin
                    if (take) begin
                        modrm_out <= byte_in;
                        reg_num_out <= byte_in[5:3];
                        if (!t_legal) begin
                            illegal_out <= 1'b1;
                            state <= ST_OP;
                        end else begin
                            // Group 6/7 resolve on the reg field here
                            kind_out <= t_kind;                          // [RQ6] [RQ7] [RQ8]
                            clocks_out <= t_clocks;                      // [RQ9] [RQ10]
                            zf_only_out <= t_zf;                         // [RQ11]
                            state <= ST_EXEC;
                            byte_ready_out <= 1'b0;
                            busy_out <= 1'b1;
                            exec_left <= t_clocks;                       // [RQ3] [RQ4] [RQ5]
                        end
                    end
                end
                ST_IMM: begin
                    if (take) begin
                        imm_out[imm_pos*8 +: 8] <= byte_in;
                        imm_pos <= imm_pos + 2'h1;
                        imm_left <= imm_left - 3'h1;
                        if (imm_left == 3'h1) begin
                            state <= ST_EXEC;
                            byte_ready_out <= 1'b0;
                            busy_out <= 1'b1;
                            exec_left <= clocks_out;
                        end
                    end
                end
                ST_EXEC: begin
                    // Miss stalls freeze the count so a hit figure stays exact
                    if (!miss_stall_in) begin                            // [RQ16]
                        exec_left <= exec_left - 4'h1;
                        if (exec_left == 4'h1) begin
                            // Ready rises with issue so the next opcode is taken without a gap
                            issue_out <= 1'b1;
                            busy_out <= 1'b0;
                            byte_ready_out <= 1'b1;
                            state <= ST_OP;
                        end
                    end
                end
                default: begin
                    state <= ST_OP;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** tb/llmdec_fetch_model.sv ***
// Behavioural fetch unit that hands bytes to the decoder one handshake at a time
`timescale 1ns/100ps
`default_nettype none
module llmdec_fetch_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // Pacing
    input  wire logic       slow_in,
    // Byte handshake
    input  wire logic       ready_in,
    output var  logic       valid_out,
    output var  logic [7:0] byte_out
);
    logic [7:0] fifo [$];
    logic [7:0] last = 8'h00;
    logic       took = 1'b0;
    logic       phase = 1'b0;
    logic       v;
    initial begin
        valid_out = 1'b0;
        byte_out  = 8'hFF;
    end
    always @(posedge clk_in) took <= valid_out && ready_in && nrst_in;
    // An offer is held until taken; slow pacing only delays the next offer
    always @(negedge clk_in) begin
        phase <= ~phase;
        v = valid_out && !took;
        if (took) last = fifo.pop_front();
        if (!v && fifo.size() > 0 && !(slow_in && phase)) begin
            v = 1'b1;
            byte_out = fifo[0];
        end else if (!v) begin
            byte_out = ~last;  // Idle bus shows junk so a stale byte cannot pass
        end
        valid_out = v;
    end
endmodule
`default_nettype wire

// *** tb/llmdec_core_asserts.sv ***
// Timing and field checks on the decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "llmdec_defines.vh"
module llmdec_core_asserts #(
    parameter ADDR_BYTES = 4
) (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       prot_mode_in,
    input wire logic       byte_valid_in,
    input wire logic       byte_ready_out,
    input wire logic       miss_stall_in,
    input wire logic       issue_out,
    input wire logic [4:0] kind_out,
    input wire logic [3:0] clocks_out,
    input wire logic       busy_out,
    input wire logic       zf_only_out,
    input wire logic       illegal_out
);
    logic [7:0] cnt;
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Edges since the last byte taken; a miss stall freezes the count
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) cnt <= 8'h00;
        else if (byte_valid_in && byte_ready_out) cnt <= 8'h00;
        else if (!miss_stall_in && cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
    chk_issue_count: assert property (
        issue_out |-> cnt == {4'h0, clocks_out}) else $error("issue late or early");
    chk_busy_refuse: assert property (
        busy_out |-> !byte_ready_out && !issue_out) else $error("byte taken while busy");
    chk_one_clock: assert property (
        issue_out && kind_out inside {`LLMDEC_K_LEA, `LLMDEC_K_MOVI, `LLMDEC_K_MOVA}
        |-> clocks_out == 4'h1) else $error("single clock count wrong");
    chk_far_count: assert property (
        issue_out && kind_out inside {`LLMDEC_K_LDPES, `LLMDEC_K_LDPFS, `LLMDEC_K_LDPGS}
        |-> clocks_out == (prot_mode_in ? 4'h9 : 4'h4)) else $error("far load count");
    chk_ss_count: assert property (
        issue_out && kind_out == `LLMDEC_K_LDPSS |-> clocks_out == (prot_mode_in ? 4'hA : 4'h4))
        else $error("stack load count");
    chk_table_count: assert property (
        issue_out && kind_out inside {`LLMDEC_K_GDT, `LLMDEC_K_IDT} |-> clocks_out == 4'hA)
        else $error("table load count");
    chk_prot_only: assert property (
        issue_out && kind_out inside {`LLMDEC_K_LDTAB, `LLMDEC_K_TASK, `LLMDEC_K_SEGLIM}
        |-> prot_mode_in) else $error("issued in real mode");
    chk_msw_count: assert property (
        issue_out && kind_out == `LLMDEC_K_MSW |-> clocks_out == 4'hB) else $error("msw count");
    chk_zero_flag: assert property (
        issue_out |-> zf_only_out == (kind_out == `LLMDEC_K_SEGLIM)) else $error("flag mark");
    chk_leave_loop: assert property (
        issue_out && kind_out inside {`LLMDEC_K_LEAVE, `LLMDEC_K_LOOP, `LLMDEC_K_LOOPNZ,
        `LLMDEC_K_LOOPZ} |-> clocks_out == (kind_out == `LLMDEC_K_LEAVE ? 4'h4 : 4'h2))
        else $error("leave or loop count");
    cov_stalled: cover property (busy_out && miss_stall_in);
    cov_refused: cover property (illegal_out);
    cov_ss_prot: cover property (issue_out && kind_out == `LLMDEC_K_LDPSS && prot_mode_in);
endmodule
bind llmdec_core llmdec_core_asserts #(.ADDR_BYTES(ADDR_BYTES)) chk (.clk_in(clk_in),
    .nrst_in(nrst_in), .prot_mode_in(prot_mode_in), .byte_valid_in(byte_valid_in),
    .byte_ready_out(byte_ready_out), .miss_stall_in(miss_stall_in), .issue_out(issue_out),
    .kind_out(kind_out), .clocks_out(clocks_out), .busy_out(busy_out),
    .zf_only_out(zf_only_out), .illegal_out(illegal_out));
`default_nettype wire

// *** tb/llmdec_core_test.sv ***
// Self-checking bench for the load, loop and short move decoder
`timescale 1ns/100ps
`default_nettype none
`include "llmdec_defines.vh"
module llmdec_core_test;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        prot_mode_in = 1'b0;
    logic        opsize32_in = 1'b0;
    logic        miss_stall_in = 1'b0;
    logic        stall_en = 1'b0;
    logic        byte_valid_in, byte_ready_out, issue_out, wide_out, zf_only_out;
    logic        busy_out, illegal_out;
    logic [7:0]  byte_in, modrm_out, op;
    logic [4:0]  kind_out;
    logic [3:0]  clocks_out;
    logic [2:0]  reg_num_out;
    logic [31:0] imm_out, r, r2;
    integer      seed, miscompares, compares, p, j, m;
    llmdec_core #(.ADDR_BYTES(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .prot_mode_in(prot_mode_in), .opsize32_in(opsize32_in), .byte_valid_in(byte_valid_in),
        .byte_in(byte_in), .byte_ready_out(byte_ready_out), .miss_stall_in(miss_stall_in),
        .issue_out(issue_out), .kind_out(kind_out), .clocks_out(clocks_out),
        .modrm_out(modrm_out), .reg_num_out(reg_num_out), .wide_out(wide_out),
        .zf_only_out(zf_only_out), .imm_out(imm_out), .busy_out(busy_out),
        .illegal_out(illegal_out));
    llmdec_fetch_model fm (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(stall_en),
        .ready_in(byte_ready_out), .valid_out(byte_valid_in), .byte_out(byte_in));
    always #2 clk_in = ~clk_in;
    always @(negedge clk_in) miss_stall_in <= stall_en && ($random(seed) % 4 == 0);
    function automatic logic [3:0] exp_clk(input logic [4:0] k, input logic pm);
        case (k)
            `LLMDEC_K_LDPES, `LLMDEC_K_LDPFS, `LLMDEC_K_LDPGS: return pm ? 4'h9 : 4'h4;
            `LLMDEC_K_LDPSS: return pm ? 4'hA : 4'h4;
            `LLMDEC_K_GDT, `LLMDEC_K_IDT: return 4'hA;
            `LLMDEC_K_LDTAB: return 4'h8;
            `LLMDEC_K_TASK, `LLMDEC_K_SEGLIM: return 4'h9;
            `LLMDEC_K_MSW: return 4'hB;
            `LLMDEC_K_LEAVE: return 4'h4;
            `LLMDEC_K_LOOP, `LLMDEC_K_LOOPNZ, `LLMDEC_K_LOOPZ: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction
    // Real mode uses a register form whose trailing byte is itself outside the slice
    function automatic logic [7:0] mr(input logic [2:0] rg);
        return prot_mode_in ? {r[7:6], rg, r[2:0]} : {2'h3, rg, 3'h7};
    endfunction
    function automatic logic [4:0] pk(input logic [4:0] k);
        return prot_mode_in ? k : `LLMDEC_K_NONE;
    endfunction
    task automatic flag(input string msg);
        $display("wrong value at %0t: %s", $time, msg);
        miscompares++;
    endtask
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic instr(input logic [63:0] b, input int n, input logic [4:0] k, input int q);
        int i;
        for (i = 0; i < n; i++) fm.fifo.push_back(b[8*i +: 8]);
        for (i = 0; i < 300 && issue_out !== 1'b1 && illegal_out !== 1'b1; i++) @(negedge clk_in);
        compares++;
        if (k === `LLMDEC_K_NONE) begin
            if (illegal_out !== 1'b1 || issue_out !== 1'b0) flag("refusal expected");
            repeat (8) @(negedge clk_in);
        end else if (issue_out !== 1'b1 || kind_out !== k
                     || clocks_out !== exp_clk(k, prot_mode_in)
                     || zf_only_out !== (k == `LLMDEC_K_SEGLIM)
                     || (k < `LLMDEC_K_LEAVE && modrm_out !== b[8*(n-1) +: 8])) begin
            flag("issue fields");
        end
        for (i = 0; i < q; i++) if (imm_out[8*i +: 8] !== b[8*(n-q+i) +: 8]) flag("immediate");
        @(negedge clk_in);
    endtask
    initial begin
        seed = 57;
        miscompares = 0;
        compares = 0;
        repeat (20) @(negedge clk_in);
        nrst_in = 1'b1;
        for (p = 0; p < 4; p++) begin
            prot_mode_in = p[0];
            stall_en = p[1];
            r = $random(seed);
            r2 = $random(seed);
            instr({mr(r[5:3]), `LLMDEC_OP_LEA}, 2, `LLMDEC_K_LEA, 0);
            instr({mr(r[5:3]), `LLMDEC_OP_LDPES}, 2, `LLMDEC_K_LDPES, 0);
            instr({mr(r[5:3]), `LLMDEC_OP2_LDPFS, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_LDPFS, 0);
            instr({mr(r[5:3]), `LLMDEC_OP2_LDPGS, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_LDPGS, 0);
            instr({mr(r[5:3]), `LLMDEC_OP2_LDPSS, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_LDPSS, 0);
            instr({mr(3'h2), `LLMDEC_OP2_GRP7, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_GDT, 0);
            instr({mr(3'h3), `LLMDEC_OP2_GRP7, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_IDT, 0);
            instr({mr(3'h2), `LLMDEC_OP2_GRP6, `LLMDEC_OP_ESC}, 3, pk(`LLMDEC_K_LDTAB), 0);
            instr({mr(3'h3), `LLMDEC_OP2_GRP6, `LLMDEC_OP_ESC}, 3, pk(`LLMDEC_K_TASK), 0);
            instr({mr(3'h6), `LLMDEC_OP2_GRP7, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_MSW, 0);
            instr({mr(r[5:3]), `LLMDEC_OP2_SEGLIM, `LLMDEC_OP_ESC}, 3,
                  pk(`LLMDEC_K_SEGLIM), 0);
            instr({mr(3'h0), `LLMDEC_OP2_GRP7, `LLMDEC_OP_ESC}, 3, `LLMDEC_K_NONE, 0);
            instr({8'hA2}, 1, `LLMDEC_K_NONE, 0);
            instr({`LLMDEC_OP_LEAVE}, 1, `LLMDEC_K_LEAVE, 0);
            instr({r2[7:0], `LLMDEC_OP_LOOP}, 2, `LLMDEC_K_LOOP, 1);
            instr({r2[15:8], `LLMDEC_OP_LOOPNZ}, 2, `LLMDEC_K_LOOPNZ, 1);
            instr({r2[23:16], `LLMDEC_OP_LOOPZ}, 2, `LLMDEC_K_LOOPZ, 1);
            for (j = 0; j < 4; j++) begin
                r = $random(seed);
                opsize32_in = r[20];
                op = {`LLMDEC_OP_MOVI_HI, r[19:16]};
                m = op[3] ? (r[20] ? 4 : 2) : 1;
                instr({r2, op}, m + 1, `LLMDEC_K_MOVI, m);
                compares++;
                if (reg_num_out !== op[2:0] || wide_out !== op[3])
                    flag("register field");
                instr({r, `LLMDEC_OP_MOVA_HI, `LLMDEC_OP_MOVA_LO, r2[j]}, 5,
                      `LLMDEC_K_MOVA, 4);
                compares++;
                if (wide_out !== r2[j])
                    flag("accumulator width");
            end
        end
        end_sim;
    end
    initial begin
        #80000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
